// File: hw/boot_sequencer.sv
`timescale 1ns/100ps
`include "boot_seq_params.svh"
module boot_sequencer
  import boot_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic restart_line_low_n,
  input wire logic supply_stable,
  input wire logic slow_clock_stable,
  input wire boot_cfg_s cfg,
  output phase_e phase,
  output boot_status_s status
);
  localparam int TW = `TICK_W;
  localparam logic [TW-1:0] WAKE_T = TW'(`WAKE_TICKS);
  localparam logic [TW-1:0] XTAL_T = TW'(`INIT_XTAL_TICKS);
  localparam logic [TW-1:0] EXT_NF_T = TW'(`INIT_EXT_NOFL_TICKS);
  localparam logic [TW-1:0] EXT_FL_T = TW'(`INIT_EXT_FL_TICKS);
  localparam logic [TW-1:0] LONG_T = TW'(`PULSE_LONG_TICKS);
  localparam logic [TW-1:0] SHORT_T = TW'(`PULSE_SHORT_TICKS);
  localparam logic [TW-1:0] ONE = TW'(1);

  logic tick;
  phase_e phase_reg, phase_next;
  logic [TW-1:0] cnt_reg, cnt_next;
  // Image time is kept in nanoseconds; the largest image at the slower
  // load rate needs more than 32 bits, so 40 are used.
  logic [39:0] img_ns_reg, img_ns_next;
  logic [39:0] img_acc_reg, img_acc_next;
  boot_status_s stat_reg, stat_next;
  logic pulse_reg, pulse_next;
  logic [TW-1:0] init_t;
  logic [TW-1:0] pulse_min;
  logic [39:0] per_kb;
  logic low;

  slow_tick_gen u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  assign low = !restart_line_low_n;

  always_comb
  begin
    init_t = XTAL_T;
    if (cfg.ext_slow_clock)
      init_t = cfg.has_flash ? EXT_FL_T : EXT_NF_T;
    pulse_min = cfg.short_pulse_ok ? SHORT_T : LONG_T;
    per_kb = cfg.has_flash ? 40'(`T_CHECK_NS_PER_KB)
                           : 40'(`T_LOAD_NS_PER_KB);
  end

  always_comb
  begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    img_ns_next = img_ns_reg;
    img_acc_next = img_acc_reg;
    pulse_next = pulse_reg;
    stat_next = stat_reg;
    stat_next.held = low;
    if (tick && cnt_reg != {TW{1'b1}})
      cnt_next = cnt_reg + ONE;
    if (low && phase_reg != ST_SUPPLY && phase_reg != ST_RESTART)
    begin
      // A restart pulse in any phase after ST_RESTART sends the sequence back to ST_RESTART.
      phase_next = ST_RESTART;
      cnt_next = '0;
      pulse_next = 1'b1;
      stat_next.boot_done = 1'b0;
    end
    else
    begin
      case (phase_reg)
        ST_SUPPLY:
        begin
          pulse_next = 1'b0;
          if (!low && !supply_stable)
            stat_next.supply_early = 1'b1;
          if (supply_stable)
          begin
            phase_next = ST_RESTART;
            cnt_next = '0;
          end
        end
        ST_RESTART:
        begin
          if (!supply_stable)
          begin
            phase_next = ST_SUPPLY;
            cnt_next = '0;
          end
          else if (!low && (!cfg.ext_slow_clock || slow_clock_stable))
          begin
            // pulse floor check
            // Power-up release is paced by the board, so only a pulse
            // that cut a running sequence is held to the floor.
            stat_next.pulse_short = pulse_reg && (cnt_reg < pulse_min);
            phase_next = ST_WAKE;
            cnt_next = '0;
          end
        end
        ST_WAKE:
          if (cnt_reg >= WAKE_T)
          begin
            phase_next = ST_INIT;
            cnt_next = '0;
          end
        ST_INIT:
          if (cnt_reg >= init_t)
          begin
            phase_next = ST_IMAGE;
            cnt_next = '0;
            img_ns_next = 40'(cfg.image_kb) * per_kb;
            img_acc_next = '0;
          end
        ST_IMAGE:
        begin
          if (img_acc_reg >= img_ns_reg)
          begin
            phase_next = ST_DONE;
            stat_next.boot_done = 1'b1;
          end
          else if (tick)
            img_acc_next = img_acc_reg + 40'(`T_SLOW_NS);
        end
        ST_DONE:
          stat_next.boot_done = 1'b1;
        default:
          phase_next = ST_SUPPLY;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      phase_reg <= ST_SUPPLY;
      cnt_reg <= '0;
      img_ns_reg <= '0;
      img_acc_reg <= '0;
      stat_reg <= '0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      img_ns_reg <= img_ns_next;
      img_acc_reg <= img_acc_next;
      stat_reg <= stat_next;
      pulse_reg <= pulse_next;
    end
  end

  assign phase = phase_reg;
  assign status = stat_reg;

  property p_wake_len;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_WAKE && phase_next == ST_INIT) |-> cnt_reg >= WAKE_T;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake phase ended early");

  property p_init_len;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_INIT && phase_next == ST_IMAGE) |-> cnt_reg >= init_t;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init phase ended early");

  property p_order;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_INIT && phase_next != ST_INIT)
      |-> phase_next inside {ST_IMAGE, ST_RESTART};
  endproperty
  a_order: assert property (p_order)
    else $error("init left to wrong phase");

  property p_done;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_DONE) |-> status.boot_done;
  endproperty
  a_done: assert property (p_done)
    else $error("done phase without flag");

  property p_ext_wait;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_RESTART && phase_next == ST_WAKE && cfg.ext_slow_clock)
      |-> slow_clock_stable;
  endproperty
  a_ext_wait: assert property (p_ext_wait)
    else $error("left restart before slow clock stable");

  property p_image_len;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_IMAGE && phase_next == ST_DONE)
      |-> img_acc_reg >= img_ns_reg;
  endproperty
  a_image_len: assert property (p_image_len)
    else $error("image phase ended early");

  sequence s_cut;
    low && phase_reg inside {ST_WAKE, ST_INIT, ST_IMAGE, ST_DONE};
  endsequence
  property p_cut;
    @(posedge core_clk) disable iff (sys_rst)
    s_cut |=> (phase_reg == ST_RESTART) && !status.boot_done;
  endproperty
  a_cut: assert property (p_cut)
    else $error("restart pulse did not cut the sequence");

  property p_pulse_flag;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_reg == ST_RESTART && phase_next == ST_WAKE && pulse_reg &&
      cnt_reg < pulse_min) |=> status.pulse_short;
  endproperty
  a_pulse_flag: assert property (p_pulse_flag)
    else $error("short restart pulse not flagged");
endmodule // boot_sequencer

// File: hw/boot_seq_params.svh
`ifndef BOOT_SEQ_PARAMS_SVH
`define BOOT_SEQ_PARAMS_SVH
`define CLK_FREQ_HZ 100000000
`define SLOW_FREQ_HZ 32768
`define SLOW_DIV_CYC (`CLK_FREQ_HZ / `SLOW_FREQ_HZ)
`define T_SLOW_NS 30518
`define T_WAKE_US 25000
`define T_INIT_XTAL_US 1100000
`define T_INIT_EXT_NOFL_NS 10300000
`define T_INIT_EXT_FL_NS 17300000
`define T_LOAD_NS_PER_KB 1700000
`define T_CHECK_NS_PER_KB 60000
`define T_PULSE_LONG_US 200000
`define T_PULSE_SHORT_US 100
`define T_REL_US 1000
`define US_TO_TICKS(us) ((((us) * 64'd32768) + 64'd999999) / 64'd1000000)
`define NS_TO_TICKS(ns) ((((ns) * 64'd32768) + 64'd999999999) / 64'd1000000000)
`define WAKE_TICKS `US_TO_TICKS(`T_WAKE_US)
`define INIT_XTAL_TICKS `US_TO_TICKS(`T_INIT_XTAL_US)
`define INIT_EXT_NOFL_TICKS `NS_TO_TICKS(`T_INIT_EXT_NOFL_NS)
`define INIT_EXT_FL_TICKS `NS_TO_TICKS(`T_INIT_EXT_FL_NS)
`define PULSE_LONG_TICKS `US_TO_TICKS(`T_PULSE_LONG_US)
`define PULSE_SHORT_TICKS `US_TO_TICKS(`T_PULSE_SHORT_US)
`define REL_TICKS `US_TO_TICKS(`T_REL_US)
`define TICK_W 24
`define KB_W 12
`endif

// File: hw/boot_seq_pkg.sv
package boot_seq_pkg;
  typedef enum logic [2:0] {
    ST_SUPPLY,
    ST_RESTART,
    ST_WAKE,
    ST_INIT,
    ST_IMAGE,
    ST_DONE
  } phase_e;
  typedef struct packed {
    logic ext_slow_clock;
    logic has_flash;
    logic short_pulse_ok;
    logic [11:0] image_kb;
  } boot_cfg_s;
  typedef struct packed {
    logic held;
    logic pulse_short;
    logic supply_early;
    logic boot_done;
  } boot_status_s;
endpackage

// File: hw/slow_tick_gen.sv
`timescale 1ns/100ps
`include "boot_seq_params.svh"
// Makes a one-cycle pulse at the 32.768 kHz slow tick rate.
module slow_tick_gen
  import boot_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic tick
);
  localparam logic [15:0] DIV_LAST = 16'(`SLOW_DIV_CYC - 1);
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic tick_reg;
  logic tick_next;

  always_comb
  begin
    tick_next = (div_reg == DIV_LAST);
    div_next = tick_next ? 16'h0000 : div_reg + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // slow_tick_gen

// File: test/restart_host_model.sv
`timescale 1ns/100ps
module restart_host_model
#(
  parameter int REL_CYC = 50
)
(
  input wire logic core_clk,
  input wire logic supply_stable,
  input wire logic slow_clock_stable,
  input wire logic ext_slow_clock,
  output logic restart_line_low_n
);
  // The release delay is far below the nominal 1 ms to keep runs short.
  initial restart_line_low_n = 1'b0;
  task automatic hold();
    @(posedge core_clk);
    #1 restart_line_low_n = 1'b0;
  endtask
  task automatic release_now();
    @(posedge core_clk);
    #1 restart_line_low_n = 1'b1;
  endtask
  task automatic power_up();
    wait (supply_stable && (!ext_slow_clock || slow_clock_stable));
    repeat (REL_CYC) @(posedge core_clk);
    #1 restart_line_low_n = 1'b1;
  endtask
  task automatic host_stop_routine();
    @(posedge core_clk);
  endtask
  task automatic pulse(input int cyc);
    host_stop_routine();
    hold();
    repeat (cyc) @(posedge core_clk);
    #1 restart_line_low_n = 1'b1;
  endtask
endmodule // restart_host_model

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import boot_seq_pkg::*;
;
  logic core_clk;
  logic sys_rst;
  logic supply_stable;
  logic slow_clock_stable;
  boot_cfg_s cfg;
  wire restart_line_low_n;
  phase_e phase;
  boot_status_s status;
  int bad_count;
  int comparisons;
  boot_sequencer i_boot_sequencer (.core_clk(core_clk), .sys_rst(sys_rst),
    .restart_line_low_n(restart_line_low_n), .supply_stable(supply_stable),
    .slow_clock_stable(slow_clock_stable), .cfg(cfg), .phase(phase),
    .status(status));
  restart_host_model i_restart_host_model (.core_clk(core_clk),
    .supply_stable(supply_stable), .slow_clock_stable(slow_clock_stable),
    .ext_slow_clock(cfg.ext_slow_clock),
    .restart_line_low_n(restart_line_low_n));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_phase(input phase_e exp);
    comparisons++;
    if (phase !== exp)
    begin
      bad_count++;
      $display("BAD phase exp %0d got %0d", exp, phase);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset();
    i_restart_host_model.hold();
    sys_rst = 1'b1;
    supply_stable = 1'b0;
    wait_cyc(12);
    chk_bit("status", 1'b1, status === '0);
    sys_rst = 1'b0;
    wait_cyc(2);
  endtask
  task automatic t_reset_vals();
    chk_phase(ST_SUPPLY);
    chk_bit("held", 1'b1, status.held);
    chk_bit("supply_early", 1'b0, status.supply_early);
    chk_bit("boot_done", 1'b0, status.boot_done);
  endtask
  task automatic t_early();
    i_restart_host_model.release_now();
    wait_cyc(3);
    chk_bit("supply_early", 1'b1, status.supply_early);
    chk_bit("held", 1'b0, status.held);
    chk_phase(ST_SUPPLY);
  endtask
  task automatic t_order();
    supply_stable = 1'b1;
    wait_cyc(3);
    chk_phase(ST_RESTART);
    supply_stable = 1'b0;
    wait_cyc(3);
    chk_phase(ST_SUPPLY);
    supply_stable = 1'b1;
    wait_cyc(3);
    chk_phase(ST_RESTART);
    i_restart_host_model.power_up();
    wait_cyc(3);
    chk_phase(ST_WAKE);
    chk_bit("pulse_short", 1'b0, status.pulse_short);
    chk_bit("supply_early", 1'b0, status.supply_early);
    wait_cyc(1000);
    chk_phase(ST_WAKE);
    chk_bit("boot_done", 1'b0, status.boot_done);
  endtask
  task automatic t_ext();
    supply_stable = 1'b1;
    wait_cyc(3);
    // The line rises before the slow clock is stable to probe the wait.
    i_restart_host_model.release_now();
    wait_cyc(3);
    chk_phase(ST_RESTART);
    slow_clock_stable = 1'b1;
    wait_cyc(3);
    chk_phase(ST_WAKE);
    chk_bit("pulse_short", 1'b0, status.pulse_short);
  endtask
  task automatic t_pulse(input int cyc, input logic exp_short);
    fork
      i_restart_host_model.pulse(cyc);
      begin
        wait_cyc(cyc / 2);
        chk_phase(ST_RESTART);
        chk_bit("held", 1'b1, status.held);
        chk_bit("boot_done", 1'b0, status.boot_done);
      end
    join
    wait_cyc(3);
    chk_bit("pulse_short", exp_short, status.pulse_short);
    chk_bit("held", 1'b0, status.held);
    chk_phase(ST_WAKE);
  endtask
  initial
  begin
    // The scenarios take about 44,000 cycles; this leaves a wide margin.
    repeat (60000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    supply_stable = 1'b0;
    slow_clock_stable = 1'b1;
    cfg = '{1'b0, 1'b0, 1'b1, 12'h010};
    do_reset();
    t_reset_vals();
    t_early();
    do_reset();
    t_order();
    // About six slow ticks and about one and a half, against a four
    // tick floor; the long floor is far above both.
    t_pulse(18400, 1'b0);
    t_pulse(4500, 1'b1);
    cfg.short_pulse_ok = 1'b0;
    do_reset();
    t_order();
    t_pulse(18400, 1'b1);
    cfg.ext_slow_clock = 1'b1;
    slow_clock_stable = 1'b0;
    do_reset();
    t_ext();
    final_report();
  end
endmodule // tb_top
